// File: dapm_ctrl.sv
// Purpose: Framing, serial readout and power-mode control of a dual sampling converter
// Assumes: All pin inputs are asynchronous to clock; result inputs come from the SAR cores on clock
// Notes:   Serial clock is oversampled, so it must stay well below a quarter of clock
// Summary of operation
// - Select falling edge samples, converts, restarts count
// - Rise at edges 10..15 aborts, stays powered
// - Sixteen cycles per result; drive until select rises
// - Further sixteen cycles give other converter's result on line A
// - Status bits name converter of following result
// - Release data line at edge thirty-two
// - Rise at edges 2..9 enters partial power-down
// - Rise before edge two keeps normal mode
// - Partial power-down keeps only reference alive
// - Dummy conversion wakes; commits past tenth edge
// - External reference ready after sixteen edges when waking from partial
// - Early rise in partial returns to partial
// - Rise 2..9 in partial enters full power-down
// - Reference select high external, low internal
// - Low select, grounded main: per-converter references
// - Latch channel pair at select fall
// - Range at select fall; coding at edge eight
`timescale 1ns/1ps
`include "dapm_params.svh"

module dapm_ctrl
	import dapm_pkg::*;
#(
	parameter logic [`DAPM_TMR_W-1:0] PowerUpFullCycles = `DAPM_TMR_W'(`DAPM_PWRUP_FULL_CYC),
	parameter logic [`DAPM_TMR_W-1:0] PowerUpIntCycles  = `DAPM_TMR_W'(`DAPM_PWRUP_INT_CYC),
	parameter logic [`DAPM_TMR_W-1:0] PowerUpExtCycles  = `DAPM_TMR_W'(`DAPM_PWRUP_EXT_CYC)
) (
	input  wire logic                  clock,
	input  wire logic                  rst_n,
	input  wire dapm_pins_s            pins,
	input  wire logic [`DAPM_RES_W-1:0] resultA,
	input  wire logic [`DAPM_RES_W-1:0] resultB,
	output logic                       serialOutA,
	output logic                       serialOutAOe,
	output logic                       serialOutB,
	output logic                       serialOutBOe,
	output logic                       sampleStrobe,
	output dapm_conv_cfg_s             convCfg,
	output dapm_ref_e                  referenceSource,
	output dapm_power_s                power,
	output dapm_mode_e                 powerMode
);

	// One status/data bit of a 16-bit frame: two zeros, pair id, converter id, result MSB first
	function automatic logic frameBit(
		input logic                   convB,
		input logic                   pairHigh,
		input logic [`DAPM_RES_W-1:0] res,
		input logic [`DAPM_POS_W-1:0] pos
	);
		logic bitVal;
		bitVal = 1'b0;
		if (pos == `DAPM_POS_PAIR) begin
			bitVal = pairHigh;
		end else if (pos == `DAPM_POS_CONV) begin
			bitVal = convB;
		end else if (pos > `DAPM_POS_CONV) begin
			bitVal = res[`DAPM_POS_MSB - pos];
		end
		return bitVal;
	endfunction : frameBit

	dapm_pins_s pinsMeta;
	dapm_pins_s pinsSync;
	dapm_pins_s pinsPrev;

	// Pins cross in as a group; edges compare the second and third stages
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			pinsMeta <= '{selectN: 1'b1, default: 1'b0};
			pinsSync <= '{selectN: 1'b1, default: 1'b0};
			pinsPrev <= '{selectN: 1'b1, default: 1'b0};
		end else begin
			pinsMeta <= pins;
			pinsSync <= pinsMeta;
			pinsPrev <= pinsSync;
		end
	end

	logic selFall;
	logic selRise;
	logic sclkFall;

	assign selFall  = pinsPrev.selectN & ~pinsSync.selectN;
	assign selRise  = ~pinsPrev.selectN & pinsSync.selectN;
	assign sclkFall = pinsPrev.serialClock & ~pinsSync.serialClock & ~pinsSync.selectN;

	logic [`DAPM_CNT_W-1:0] edgeCount;
	logic [`DAPM_CNT_W-1:0] next_edgeCount;
	dapm_mode_e             mode;
	dapm_mode_e             next_mode;
	logic                   waking;
	logic                   next_waking;
	logic                   fromFull;
	logic                   next_fromFull;
	logic                   ready;
	logic                   next_ready;
	logic [`DAPM_TMR_W-1:0] wakeTimer;
	logic [`DAPM_TMR_W-1:0] next_wakeTimer;
	logic [`DAPM_TMR_W-1:0] wakeTarget;
	dapm_conv_cfg_s         next_convCfg;
	dapm_ref_e              next_referenceSource;
	dapm_power_s            next_power;
	logic                   next_serialOutA;
	logic                   next_serialOutAOe;
	logic                   next_serialOutB;
	logic                   next_serialOutBOe;
	logic [`DAPM_CNT_W-1:0] countInc;
	logic [`DAPM_POS_W-1:0] framePos;
	logic                   secondHalf;
	logic                   extRef;

	assign countInc   = edgeCount + `DAPM_CNT_W'(1);
	assign framePos   = countInc[`DAPM_POS_W-1:0];
	assign secondHalf = countInc >= `DAPM_EDGE_FRAME;
	assign extRef     = referenceSource != DAPM_REF_INTERNAL;
	assign wakeTarget = fromFull ? PowerUpFullCycles : (extRef ? PowerUpExtCycles : PowerUpIntCycles);

	always_comb begin
		next_edgeCount    = edgeCount;
		next_mode         = mode;
		next_waking       = waking;
		next_fromFull     = fromFull;
		next_ready        = ready;
		next_wakeTimer    = wakeTimer;
		next_convCfg      = convCfg;
		next_serialOutA   = serialOutA;
		next_serialOutAOe = serialOutAOe;
		next_serialOutB   = serialOutB;
		next_serialOutBOe = serialOutBOe;

		// Wake time runs from the dummy conversion's select fall
		if (waking && wakeTimer != wakeTarget) begin
			next_wakeTimer = wakeTimer + `DAPM_TMR_W'(1);
		end
		// ready once committed and wake time is over
		if (waking && mode == DAPM_NORMAL && wakeTimer == wakeTarget) begin
			next_waking = 1'b0;
			next_ready  = 1'b1;
		end

		if (selFall) begin
			// restart count, drive first frame bit
			next_edgeCount    = '0;
			next_serialOutAOe = 1'b1;
			next_serialOutBOe = 1'b1;
			next_serialOutA   = 1'b0;
			next_serialOutB   = 1'b0;
			next_convCfg.channelSecond = pinsSync.channelPairSelect;
			// range and default coding at select fall
			next_convCfg.rangeWide  = pinsSync.rangeSel;
			next_convCfg.codingTwos = pinsSync.rangeSel;
			// start powering up on a dummy conversion
			if (mode != DAPM_NORMAL) begin
				next_waking    = 1'b1;
				next_fromFull  = mode == DAPM_FULL;
				next_wakeTimer = '0;
				next_ready     = 1'b0;
			end
		end else if (selRise) begin
			// early release always tri-states both lines
			next_serialOutAOe = 1'b0;
			next_serialOutBOe = 1'b0;
			if (edgeCount >= `DAPM_EDGE_GLITCH && edgeCount < `DAPM_EDGE_KEEP) begin
				// normal goes to partial; partial goes to full
				next_mode   = (mode == DAPM_NORMAL) ? DAPM_PARTIAL : DAPM_FULL;
				next_waking = 1'b0;
				next_ready  = 1'b0;
			end else if (edgeCount < `DAPM_EDGE_GLITCH && mode != DAPM_NORMAL) begin
				// glitch on select powers back down
				next_waking = 1'b0;
			end
			// glitch in normal mode changes nothing
		end else if (sclkFall) begin
			if (edgeCount != `DAPM_EDGE_SAT) begin
				next_edgeCount = countInc;
			end
			// coding follows level at edge eight
			if (countInc == `DAPM_EDGE_CODING) begin
				next_convCfg.codingTwos = pinsSync.rangeSel;
			end
			// held past tenth edge: wake is committed
			if (countInc == `DAPM_EDGE_KEEP && mode != DAPM_NORMAL && waking) begin
				next_mode = DAPM_NORMAL;
			end
			// external reference, waking from partial: full power at sixteen edges
			if (countInc == `DAPM_EDGE_FRAME && waking && !fromFull && extRef) begin
				next_waking = 1'b0;
				next_ready  = 1'b1;
			end
			if (edgeCount < `DAPM_EDGE_DUAL) begin
				next_serialOutA = frameBit(secondHalf, convCfg.channelSecond,
					secondHalf ? resultB : resultA, framePos);
				// line B stays driven after its frame
				next_serialOutB = secondHalf ? 1'b0 : frameBit(1'b1, convCfg.channelSecond, resultB, framePos);
			end
			// line A carries the second result in edges 16..31
			if (countInc == `DAPM_EDGE_DUAL) begin
				next_serialOutAOe = 1'b0;
				next_serialOutBOe = 1'b0;
			end
		end

		if (pinsSync.refSelect) begin
			next_referenceSource = DAPM_REF_EXT_MAIN;
		end else if (pinsSync.vrefGrounded) begin
			next_referenceSource = DAPM_REF_EXT_EACH;
		end else begin
			next_referenceSource = DAPM_REF_INTERNAL;
		end

		// partial keeps only the reference and its buffer
		next_power.analogOn    = next_mode == DAPM_NORMAL || next_waking;
		next_power.referenceOn = next_mode != DAPM_FULL || next_waking;
		next_power.powerReady  = next_ready && next_mode == DAPM_NORMAL;
	end

	// Reset assumes normal mode and a ready part
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			edgeCount       <= `DAPM_EDGE_SAT;
			mode            <= DAPM_NORMAL;
			waking          <= 1'b0;
			fromFull        <= 1'b0;
			ready           <= 1'b1;
			wakeTimer       <= '0;
			convCfg         <= '0;
			referenceSource <= DAPM_REF_INTERNAL;
			power           <= '{analogOn: 1'b1, referenceOn: 1'b1, powerReady: 1'b1};
			powerMode       <= DAPM_NORMAL;
			serialOutA      <= 1'b0;
			serialOutAOe    <= 1'b0;
			serialOutB      <= 1'b0;
			serialOutBOe    <= 1'b0;
			sampleStrobe    <= 1'b0;
		end else begin
			edgeCount       <= next_edgeCount;
			mode            <= next_mode;
			waking          <= next_waking;
			fromFull        <= next_fromFull;
			ready           <= next_ready;
			wakeTimer       <= next_wakeTimer;
			convCfg         <= next_convCfg;
			referenceSource <= next_referenceSource;
			power           <= next_power;
			powerMode       <= next_mode;
			serialOutA      <= next_serialOutA;
			serialOutAOe    <= next_serialOutAOe;
			serialOutB      <= next_serialOutB;
			serialOutBOe    <= next_serialOutBOe;
			sampleStrobe    <= selFall;
		end
	end

endmodule : dapm_ctrl

// File: dapm_ctrl_assertions.sv
// Purpose: Temporal checks on the converter control ports
// Assumes: Pin changes reach the outputs three to four clocks later
// Notes:   Bound to every dapm_ctrl instance
`timescale 1ns/1ps
`include "dapm_params.svh"

module dapm_ctrl_assertions
	import dapm_pkg::*;
#(
	parameter logic [`DAPM_TMR_W-1:0] PowerUpFullCycles = `DAPM_TMR_W'(`DAPM_PWRUP_FULL_CYC)
) (
	input wire logic                    clock,
	input wire logic                    rst_n,
	input wire dapm_pins_s              pins,
	input wire logic [`DAPM_RES_W-1:0]  resultA,
	input wire logic [`DAPM_RES_W-1:0]  resultB,
	input wire logic                    serialOutA,
	input wire logic                    serialOutAOe,
	input wire logic                    serialOutB,
	input wire logic                    serialOutBOe,
	input wire logic                    sampleStrobe,
	input wire dapm_conv_cfg_s          convCfg,
	input wire dapm_ref_e               referenceSource,
	input wire dapm_power_s             power,
	input wire dapm_mode_e              powerMode
);
	default clocking cb @(posedge clock); endclocking
	default disable iff (!rst_n);

	a_strobe_single_pulse: assert property (sampleStrobe |=> !sampleStrobe)
		else $error("sample strobe longer than one cycle");
	a_strobe_opens_lines: assert property (sampleStrobe |-> serialOutAOe && serialOutBOe && !serialOutA && !serialOutB)
		else $error("lines not opened with the sample strobe");
	a_select_rise_releases: assert property ($rose(pins.selectN) |-> ##[1:5] (!serialOutAOe && !serialOutBOe))
		else $error("data lines still driven after select rose");
	a_normal_never_full: assert property (powerMode == DAPM_NORMAL |=> powerMode != DAPM_FULL)
		else $error("full power-down reached straight from normal");
	a_partial_keeps_ref: assert property (powerMode == DAPM_PARTIAL |-> power.referenceOn)
		else $error("reference off in partial power-down");
	a_partial_entry_off: assert property ($changed(powerMode) && powerMode == DAPM_PARTIAL |-> !power.analogOn && !power.powerReady)
		else $error("analog still on entering partial power-down");
	a_full_entry_off: assert property ($changed(powerMode) && powerMode == DAPM_FULL |-> power == 3'h0)
		else $error("circuits still on entering full power-down");
	a_ref_external_main: assert property (pins.refSelect [*5] |-> referenceSource == DAPM_REF_EXT_MAIN)
		else $error("main external reference not chosen");
	a_ref_each_conv: assert property ((!pins.refSelect && pins.vrefGrounded) [*5] |-> referenceSource == DAPM_REF_EXT_EACH)
		else $error("per-converter reference not chosen");
	a_ready_needs_normal: assert property (power.powerReady |-> powerMode == DAPM_NORMAL)
		else $error("ready reported outside normal mode");
endmodule : dapm_ctrl_assertions

bind dapm_ctrl dapm_ctrl_assertions #(.PowerUpFullCycles(PowerUpFullCycles)) chk (.clock(clock), .rst_n(rst_n),
	.pins(pins), .resultA(resultA), .resultB(resultB), .serialOutA(serialOutA), .serialOutAOe(serialOutAOe),
	.serialOutB(serialOutB), .serialOutBOe(serialOutBOe), .sampleStrobe(sampleStrobe), .convCfg(convCfg),
	.referenceSource(referenceSource), .power(power), .powerMode(powerMode));

// File: dapm_ctrl_tb.sv
// Purpose: Self-checking bench for the converter control block
// Assumes: Shortened full power-down wake count; inputs change one ns after a rising edge
// Notes:   Released data lines show the inverse of their last value
`timescale 1ns/1ps

module dapm_ctrl_tb
	import dapm_pkg::*;
;
	typedef struct packed {
		logic        refSel;
		logic        vrefGnd;
		logic [5:0]  edges;
		dapm_ref_e   refSrc;
		dapm_mode_e  mode;
		dapm_power_s pwr;
	} dapm_row_s;

	logic clock, rst_n, hostSel, hostSclk, rangeSel, chanSel, refSel, vrefGnd;
	logic serialOutA, serialOutAOe, serialOutB, serialOutBOe, sampleStrobe, lineA, lineB;
	logic [11:0]    resultA, resultB;
	logic [31:0]    shiftA, shiftB;
	dapm_pins_s     pins;
	dapm_conv_cfg_s convCfg;
	dapm_ref_e      referenceSource;
	dapm_power_s    power;
	dapm_mode_e     powerMode;
	int             nFail = 0;
	int             samplesChecked = 0;
	dapm_row_s rows [11] = '{
		'{1'b0, 1'b0, 6'h01, DAPM_REF_INTERNAL, DAPM_NORMAL, 3'h7},
		'{1'b0, 1'b1, 6'h05, DAPM_REF_EXT_EACH, DAPM_PARTIAL, 3'h2},
		'{1'b0, 1'b0, 6'h01, DAPM_REF_INTERNAL, DAPM_PARTIAL, 3'h2},
		'{1'b1, 1'b1, 6'h05, DAPM_REF_EXT_MAIN, DAPM_FULL, 3'h0},
		'{1'b0, 1'b0, 6'h0C, DAPM_REF_INTERNAL, DAPM_NORMAL, 3'h7},
		'{1'b0, 1'b0, 6'h03, DAPM_REF_INTERNAL, DAPM_PARTIAL, 3'h2},
		'{1'b1, 1'b0, 6'h10, DAPM_REF_EXT_MAIN, DAPM_NORMAL, 3'h7},
		'{1'b0, 1'b0, 6'h0A, DAPM_REF_INTERNAL, DAPM_NORMAL, 3'h7},
		'{1'b0, 1'b0, 6'h02, DAPM_REF_INTERNAL, DAPM_PARTIAL, 3'h2},
		'{1'b0, 1'b0, 6'h09, DAPM_REF_INTERNAL, DAPM_FULL, 3'h0},
		'{1'b0, 1'b0, 6'h0A, DAPM_REF_INTERNAL, DAPM_NORMAL, 3'h7}};

	assign pins = {hostSel, hostSclk, rangeSel, chanSel, refSel, vrefGnd};
	assign lineA = serialOutAOe ? serialOutA : ~serialOutA;
	assign lineB = serialOutBOe ? serialOutB : ~serialOutB;

	dapm_ctrl #(.PowerUpFullCycles(18'h00028), .PowerUpIntCycles(18'h000C8), .PowerUpExtCycles(18'h00032)) uut (
		.clock(clock), .rst_n(rst_n), .pins(pins), .resultA(resultA), .resultB(resultB),
		.serialOutA(serialOutA), .serialOutAOe(serialOutAOe), .serialOutB(serialOutB),
		.serialOutBOe(serialOutBOe), .sampleStrobe(sampleStrobe), .convCfg(convCfg),
		.referenceSource(referenceSource), .power(power), .powerMode(powerMode));

	dapm_host host (.clock(clock), .lineA(lineA), .lineB(lineB), .selectN(hostSel), .serialClock(hostSclk),
		.shiftA(shiftA), .shiftB(shiftB));

	task automatic check(input string what, input logic [31:0] expV, input logic [31:0] gotV);
		samplesChecked++;
		if (gotV !== expV) begin
			$display("mismatch %s expected %h seen %h", what, expV, gotV);
			nFail++;
		end
	endtask : check

	task automatic finish_test;
		if (nFail == 0 && samplesChecked > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask : finish_test

	initial begin
		clock = 1'b0;
		forever #10 clock = ~clock;
	end

	initial begin
		#200000;
		nFail++;
		finish_test();
	end

	initial begin
		rst_n = 1'b0;
		{rangeSel, chanSel, refSel, vrefGnd} = 4'h0;
		resultA = 12'hA5C;
		resultB = 12'h3B1;
		repeat (10) @(posedge clock);
		#1 rst_n = 1'b1;
		host.tick(4);
		foreach (rows[i]) begin
			refSel = rows[i].refSel;
			vrefGnd = rows[i].vrefGnd;
			// Results move every row so the core inputs are never static
			resultA = resultA + 12'h111;
			resultB = ~resultB;
			host.frame(rows[i].edges);
			host.stop();
			check("powerMode", rows[i].mode, powerMode);
			check("power", rows[i].pwr, power);
			check("referenceSource", rows[i].refSrc, referenceSource);
			check("outputEnable", 2'h0, {serialOutAOe, serialOutBOe});
		end
		// Range high at select fall, low before the eighth edge
		chanSel = 1'b1;
		rangeSel = 1'b1;
		fork
			host.frame(32);
			begin
				host.tick(30);
				rangeSel = 1'b0;
			end
		join
		check("outputEnable", 2'h0, {serialOutAOe, serialOutBOe});
		check("shiftA", {3'h1, 1'b0, resultA, 3'h1, 1'b1, resultB}, shiftA);
		check("shiftB", {3'h1, 1'b1, resultB, 16'h0000}, shiftB);
		check("convCfg", 3'h6, convCfg);
		host.stop();
		// Reset in mid-frame
		host.frame(6);
		rst_n = 1'b0;
		host.tick(2);
		check("resetState", {4'h0, DAPM_NORMAL, 3'h7, DAPM_REF_INTERNAL, 3'h0, 1'b0},
			{serialOutAOe, serialOutBOe, serialOutA, serialOutB, powerMode, power, referenceSource, convCfg,
			sampleStrobe});
		host.stop();
		rst_n = 1'b1;
		host.tick(4);
		host.frame(1);
		host.stop();
		check("powerMode", DAPM_NORMAL, powerMode);
		finish_test();
	end
endmodule : dapm_ctrl_tb

// File: dapm_host.sv
// Purpose: Host serial port that frames conversions and shifts results in
// Assumes: Serial clock idles high and stands still between frames
// Notes:   Half period of five clocks keeps edges visible to the oversampler
`timescale 1ns/1ps

module dapm_host (
	input  wire logic   clock,
	input  wire logic   lineA,
	input  wire logic   lineB,
	output logic        selectN,
	output logic        serialClock,
	output logic [31:0] shiftA,
	output logic [31:0] shiftB
);
	localparam int Half = 5;

	initial begin
		selectN = 1'b1;
		serialClock = 1'b1;
		shiftA = 32'h0;
		shiftB = 32'h0;
	end

	task automatic tick(input int n);
		repeat (n) @(posedge clock);
		#1;
	endtask : tick

	// select held low over the falling edges
	task automatic frame(input int edges);
		tick(1);
		selectN = 1'b0;
		for (int k = 0; k < edges; k++) begin
			tick(Half);
			shiftA = {shiftA[30:0], lineA};
			shiftB = {shiftB[30:0], lineB};
			serialClock = 1'b0;
			tick(Half);
			serialClock = 1'b1;
		end
		tick(Half);
	endtask : frame

	task automatic stop;
		selectN = 1'b1;
		tick(8);
	endtask : stop
endmodule : dapm_host

// File: dapm_params.svh
// Purpose: Constants for the dual converter power-mode and serial framing control
// Assumes: 50 MHz system clock; edge counts are serial clock falling edges after select falls
// Notes:   Definitions only
`ifndef DAPM_PARAMS_SVH
`define DAPM_PARAMS_SVH

`define DAPM_CLK_MHZ         50
`define DAPM_PWRUP_FULL_US   4000
`define DAPM_PWRUP_INT_US    4
`define DAPM_PWRUP_EXT_US    1
`define DAPM_PWRUP_FULL_CYC  (`DAPM_PWRUP_FULL_US * `DAPM_CLK_MHZ)
`define DAPM_PWRUP_INT_CYC   (`DAPM_PWRUP_INT_US * `DAPM_CLK_MHZ)
`define DAPM_PWRUP_EXT_CYC   (`DAPM_PWRUP_EXT_US * `DAPM_CLK_MHZ)
`define DAPM_TMR_W           18

`define DAPM_CNT_W           6
`define DAPM_EDGE_GLITCH     6'h02
`define DAPM_EDGE_CODING     6'h08
`define DAPM_EDGE_KEEP       6'h0A
`define DAPM_EDGE_FRAME      6'h10
`define DAPM_EDGE_DUAL       6'h20
`define DAPM_EDGE_SAT        6'h21

`define DAPM_RES_W           12
`define DAPM_POS_W           4
`define DAPM_POS_PAIR        4'h2
`define DAPM_POS_CONV        4'h3
`define DAPM_POS_MSB         4'hF

`endif

// File: dapm_pkg.sv
// Purpose: Types shared by the converter control block
// Assumes: Constants come from dapm_params.svh
// Notes:   Pin group is sampled as one vector through the synchroniser
package dapm_pkg;

	typedef enum logic [1:0] {
		DAPM_NORMAL,
		DAPM_PARTIAL,
		DAPM_FULL
	} dapm_mode_e;

	typedef enum logic [1:0] {
		DAPM_REF_INTERNAL,
		DAPM_REF_EXT_MAIN,
		DAPM_REF_EXT_EACH
	} dapm_ref_e;

	typedef struct packed {
		logic selectN;
		logic serialClock;
		logic rangeSel;
		logic channelPairSelect;
		logic refSelect;
		logic vrefGrounded;
	} dapm_pins_s;

	typedef struct packed {
		logic channelSecond;
		logic rangeWide;
		logic codingTwos;
	} dapm_conv_cfg_s;

	typedef struct packed {
		logic analogOn;
		logic referenceOn;
		logic powerReady;
	} dapm_power_s;

endpackage : dapm_pkg
